// >>> design/rsd_pkg.sv
// Purpose: shared constants for the reset, strap and debug-select block
// Assumes: sys_clk at 100 MHz
// Notes:   bit positions of the synchronised pin vector live here too
package rsd_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned POR_HOLD_NS    = 1000;   // power-on reset hold time
    localparam int unsigned POR_CYCLES     = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned POR_CNT_W      = 8;
    localparam logic [7:0]  POR_LAST       = 8'(POR_CYCLES - 1);

    // ---------------------------------------------------------------
    // synchronised input vector layout
    // ---------------------------------------------------------------
    localparam int unsigned SYNC_W         = 8;
    localparam int unsigned SY_MASTER      = 0;
    localparam int unsigned SY_CHIP        = 1;
    localparam int unsigned SY_BOOT        = 2;
    localparam int unsigned SY_DEBUG       = 3;
    localparam int unsigned SY_TCK         = 4;
    localparam int unsigned SY_TMS         = 5;
    localparam int unsigned SY_TDI         = 6;
    localparam int unsigned SY_TRST        = 7;

    // ---------------------------------------------------------------
    // reset values of latched straps
    // ---------------------------------------------------------------
    localparam logic        BOOT_FLASH_RST = 1'h1;   // flash boot until captured
    localparam logic        EMU_MODE_RST   = 1'h0;   // boundary scan until captured
endpackage

// >>> design/rsd_sync2.sv
// Purpose: two-flop synchroniser for a vector of asynchronous inputs
// Assumes: every bit is an independent level
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rsd_sync2
    import rsd_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // data
    input  wire logic [SYNC_W-1:0] async_in,
    output logic      [SYNC_W-1:0] sync_out
);
    logic [SYNC_W-1:0] stage1_ff;

    // two-stage metastability filter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_ff <= '0;
            sync_out  <= '0;
        end else begin
            stage1_ff <= async_in;
            sync_out  <= stage1_ff;
        end
    end
endmodule
`default_nettype wire

// >>> design/rsd_top.sv
// What this block does
// - chip_reset_n is driven low after power-on and an outside pull-down resets the baseband.
// - boot_source_strap is taken at master reset release: high boots flash, low boots ROM.
// - debug_mode_strap is an input during reset, captured at release and held until next reset.
// - A latched high debug strap routes the test port to emulation, low to boundary scan.
// - After release in emulation mode the debug pin turns output and drives returned_test_clock.
// - TCK is synchronised to the system clock, so TDO timing varies cycle to cycle.
// - test_logic_reset_n low resets the test logic apart from the master reset.
//
// Purpose: reset handling, boot and debug straps, and test port routing
// Assumes: all pins are asynchronous to sys_clk and pass the two-flop synchroniser
// Notes:   open-collector pins only ever drive low; the bench resolves the wire
`timescale 1ns/1ps
`default_nettype none
module rsd_top
    import rsd_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // master reset pin, open collector
    input  wire logic master_reset_n_in,
    output logic      master_reset_n_out,
    output logic      master_reset_n_oe,
    // baseband reset pin, open collector
    input  wire logic chip_reset_n_in,
    output logic      chip_reset_n_out,
    output logic      chip_reset_n_oe,
    // straps
    input  wire logic boot_source_strap,
    input  wire logic debug_mode_strap_in,
    output logic      debug_mode_strap_out,
    output logic      debug_mode_strap_oe,
    // test port pins
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic test_logic_reset_n,
    output logic      tdo,
    // internal resets and boot choice
    output logic      module_reset_n,
    output logic      baseband_reset_n,
    output logic      boot_from_flash,
    output logic      emulation_mode,
    // emulation target side
    output logic      emu_tck_rise,
    output logic      emu_tck_fall,
    output logic      emu_tms,
    output logic      emu_tdi,
    output logic      emu_test_reset_n,
    input  wire logic emu_tdo,
    // boundary-scan target side
    output logic      scan_tck_rise,
    output logic      scan_tck_fall,
    output logic      scan_tms,
    output logic      scan_tdi,
    output logic      scan_test_reset_n,
    input  wire logic scan_tdo
);
    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] pin_s;
    logic              master_s;
    logic              chip_s;
    logic              tck_s;
    logic              trst_s;
    logic              master_prev_ff;
    logic              tck_prev_ff;
    logic              master_rise;
    logic              tck_rise;
    logic              tck_fall;

    rsd_sync2 u_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in ({test_logic_reset_n, tdi, tms, tck, debug_mode_strap_in,
                    boot_source_strap, chip_reset_n_in, master_reset_n_in}),
        .sync_out (pin_s)
    );

    assign master_s    = pin_s[SY_MASTER];
    assign chip_s      = pin_s[SY_CHIP];
    assign tck_s       = pin_s[SY_TCK];
    assign trst_s      = pin_s[SY_TRST];
    assign master_rise = master_s & ~master_prev_ff;
    assign tck_rise    = tck_s & ~tck_prev_ff;
    assign tck_fall    = ~tck_s & tck_prev_ff;

    // edge history for master reset and test clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            master_prev_ff <= 1'h0;
            tck_prev_ff    <= 1'h0;
        end else begin
            master_prev_ff <= master_s;
            tck_prev_ff    <= tck_s;
        end
    end

    // ---------------------------------------------------------------
    // power-on reset and reset pins
    // ---------------------------------------------------------------
    logic [POR_CNT_W-1:0] por_cnt_ff;
    logic                 por_active_ff;
    logic                 module_reset_n_ff;
    logic                 baseband_reset_n_ff;

    // power-on hold: both open-collector pins pulled low for the hold time
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt_ff    <= '0;
            por_active_ff <= 1'h1;
        end else if (por_active_ff) begin
            por_cnt_ff    <= por_cnt_ff + 8'h01;
            por_active_ff <= (por_cnt_ff != POR_LAST);
        end
    end

    // internal resets follow the pins, so any outside pull-down holds them
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            module_reset_n_ff   <= 1'h0;
            baseband_reset_n_ff <= 1'h0;
        end else begin
            module_reset_n_ff   <= master_s & ~por_active_ff;
            baseband_reset_n_ff <= chip_s & ~por_active_ff;
        end
    end

    assign master_reset_n_out = 1'h0;
    assign chip_reset_n_out   = 1'h0;
    assign master_reset_n_oe  = por_active_ff;
    assign chip_reset_n_oe    = por_active_ff;
    assign module_reset_n     = module_reset_n_ff;
    assign baseband_reset_n   = baseband_reset_n_ff;

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    logic boot_from_flash_ff;
    logic emulation_mode_ff;

    // straps sampled on the release edge of master reset, held otherwise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            boot_from_flash_ff <= BOOT_FLASH_RST;
            emulation_mode_ff  <= EMU_MODE_RST;
        end else if (master_rise) begin
            boot_from_flash_ff <= pin_s[SY_BOOT];
            emulation_mode_ff  <= pin_s[SY_DEBUG];
        end
    end

    assign boot_from_flash = boot_from_flash_ff;
    assign emulation_mode  = emulation_mode_ff;

    // ---------------------------------------------------------------
    // returned test clock on the shared debug pin
    // ---------------------------------------------------------------
    logic dbg_out_ff;
    logic dbg_oe_ff;

    // pin stays an input during reset, drives the synced clock after release in emulation mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_out_ff <= 1'h0;
            dbg_oe_ff  <= 1'h0;
        end else begin
            dbg_oe_ff  <= emulation_mode_ff & master_prev_ff;
            dbg_out_ff <= tck_s;
        end
    end

    assign debug_mode_strap_out = dbg_out_ff;
    assign debug_mode_strap_oe  = dbg_oe_ff;

    // ---------------------------------------------------------------
    // test port routing
    // ---------------------------------------------------------------
    logic emu_rise_ff;
    logic emu_fall_ff;
    logic emu_tms_ff;
    logic emu_tdi_ff;
    logic emu_trst_ff;
    logic scan_rise_ff;
    logic scan_fall_ff;
    logic scan_tms_ff;
    logic scan_tdi_ff;
    logic scan_trst_ff;
    logic tdo_ff;

    // clock edges and data go only to the selected target
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            emu_rise_ff  <= 1'h0;
            emu_fall_ff  <= 1'h0;
            emu_tms_ff   <= 1'h0;
            emu_tdi_ff   <= 1'h0;
            scan_rise_ff <= 1'h0;
            scan_fall_ff <= 1'h0;
            scan_tms_ff  <= 1'h0;
            scan_tdi_ff  <= 1'h0;
        end else begin
            emu_rise_ff  <= emulation_mode_ff & tck_rise;
            emu_fall_ff  <= emulation_mode_ff & tck_fall;
            emu_tms_ff   <= emulation_mode_ff & pin_s[SY_TMS];
            emu_tdi_ff   <= emulation_mode_ff & pin_s[SY_TDI];
            scan_rise_ff <= ~emulation_mode_ff & tck_rise;
            scan_fall_ff <= ~emulation_mode_ff & tck_fall;
            scan_tms_ff  <= ~emulation_mode_ff & pin_s[SY_TMS];
            scan_tdi_ff  <= ~emulation_mode_ff & pin_s[SY_TDI];
        end
    end

    // test reset acts on its own, the deselected target is held in reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            emu_trst_ff  <= 1'h0;
            scan_trst_ff <= 1'h0;
        end else begin
            emu_trst_ff  <= trst_s & emulation_mode_ff;
            scan_trst_ff <= trst_s & ~emulation_mode_ff;
        end
    end

    // tdo from the selected target, valid some cycles after the tck edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tdo_ff <= 1'h0;
        end else begin
            tdo_ff <= emulation_mode_ff ? emu_tdo : scan_tdo;
        end
    end

    assign emu_tck_rise      = emu_rise_ff;
    assign emu_tck_fall      = emu_fall_ff;
    assign emu_tms           = emu_tms_ff;
    assign emu_tdi           = emu_tdi_ff;
    assign emu_test_reset_n  = emu_trst_ff;
    assign scan_tck_rise     = scan_rise_ff;
    assign scan_tck_fall     = scan_fall_ff;
    assign scan_tms          = scan_tms_ff;
    assign scan_tdi          = scan_tdi_ff;
    assign scan_test_reset_n = scan_trst_ff;
    assign tdo               = tdo_ff;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_module_held_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
        !master_s |=> !module_reset_n_ff)
        else $error("module left reset while master reset pin low");

    a_baseband_ext_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
        !chip_s |=> !baseband_reset_n_ff)
        else $error("baseband not reset by chip reset pin");

    a_boot_strap_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
        master_rise |=> boot_from_flash_ff == $past(pin_s[SY_BOOT]))
        else $error("boot strap not captured at release");

    a_debug_strap_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !master_rise |=> $stable(emulation_mode_ff))
        else $error("debug mode changed outside reset release");

    a_route_select_emu: assert property (@(posedge sys_clk) disable iff (!nrst)
        (emu_rise_ff || emu_fall_ff) |-> $past(emulation_mode_ff) && !scan_rise_ff && !scan_fall_ff)
        else $error("test clock routed to deselected target");

    a_returned_test_clock_drive_out: assert property (@(posedge sys_clk) disable iff (!nrst)
        (emulation_mode_ff && master_prev_ff) |=> dbg_oe_ff && dbg_out_ff == $past(tck_s))
        else $error("returned test clock not driven after release");

    a_tck_edge_pass: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tck_rise && emulation_mode_ff) |=> emu_rise_ff ##1 !emu_rise_ff)
        else $error("synced test clock edge not one pulse");

    a_test_reset_indep: assert property (@(posedge sys_clk) disable iff (!nrst)
        !trst_s |=> !emu_trst_ff && !scan_trst_ff)
        else $error("test logic not reset by test reset");
endmodule
`default_nettype wire

// >>> testbench/rsd_host_model.sv
// Purpose: host reset circuit and debugger facing the reset/strap/debug pins
// Assumes: reset pins are open collector with pull-ups; tck halves are 80 ns, longer while paced on the returned clock
// Notes:   the strap is released 100 ns after reset release, then shows its inverse
`timescale 1ns/1ps
`default_nettype none
module rsd_host_model
(
    // bench controls
    input  wire logic hold_master,
    input  wire logic hold_chip,
    input  wire logic boot_level,
    input  wire logic debug_level,
    input  wire logic tck_run,
    // device side of the shared pins
    input  wire logic master_oe,
    input  wire logic chip_oe,
    input  wire logic strap_out,
    input  wire logic strap_oe,
    // resolved pin levels
    output logic      master_wire,
    output logic      chip_wire,
    output logic      boot_wire,
    output logic      strap_wire,
    output logic      tck
);
    logic strap_drive = 1'b1;

    // open collector pins, pulled up unless someone pulls low
    assign master_wire = !(hold_master || master_oe);
    assign chip_wire   = !(hold_chip || chip_oe);
    assign boot_wire   = boot_level;
    // strap driven through reset and a little beyond, then released
    assign strap_wire  = strap_oe ? strap_out : (strap_drive ? debug_level : !debug_level);

    // release of the strap trails the reset release by a hold time
    always @(master_wire) begin
        if (!master_wire) begin
            strap_drive = 1'b1;
        end else begin
            #100;
            strap_drive = !master_wire;
        end
    end

    // test clock stands low until asked to run
    initial begin
        tck = 1'b0;
        forever begin
            wait (tck_run);
            for (int i = 0; i < 2; i++) begin
                #80;
                tck = !tck;
                // in emulation pace on the returned clock, bounded
                if (strap_oe) begin
                    for (int k = 0; k < 50 && strap_out !== tck; k++) begin
                        #10;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the reset, strap and debug-select block
// Assumes: sys_clk 100 MHz, inputs changed on the falling edge
// Notes:   pin levels are resolved by the host model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rsd_pkg::*;
    logic sys_clk, nrst, hold_master, hold_chip, boot_level, debug_level, tck_run;
    logic tms, tdi, trst_n, emu_tdo, scan_tdo;
    logic m_wire, c_wire, b_wire, s_wire, tck;
    logic m_oe, c_oe, s_out, s_oe, tdo, mod_rst_n, bb_rst_n, boot_flash, emu_mode;
    logic emu_rise, emu_tms, emu_tdi, emu_trst_n, scan_rise, scan_tms, scan_tdi, scan_trst_n;
    logic emu_fall, scan_fall, m_out, c_out;
    int   err_total, tests_run, cycles, n_emu, n_scan, n_tck, n_returned_test_clock, n_emu_f, n_scan_f;

    rsd_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .master_reset_n_in(m_wire),
        .master_reset_n_out(m_out), .master_reset_n_oe(m_oe), .chip_reset_n_in(c_wire),
        .chip_reset_n_out(c_out), .chip_reset_n_oe(c_oe), .boot_source_strap(b_wire),
        .debug_mode_strap_in(s_wire), .debug_mode_strap_out(s_out),
        .debug_mode_strap_oe(s_oe), .tck(tck), .tms(tms), .tdi(tdi),
        .test_logic_reset_n(trst_n), .tdo(tdo), .module_reset_n(mod_rst_n),
        .baseband_reset_n(bb_rst_n), .boot_from_flash(boot_flash), .emulation_mode(emu_mode),
        .emu_tck_rise(emu_rise), .emu_tck_fall(emu_fall), .emu_tms(emu_tms), .emu_tdi(emu_tdi),
        .emu_test_reset_n(emu_trst_n), .emu_tdo(emu_tdo), .scan_tck_rise(scan_rise),
        .scan_tck_fall(scan_fall), .scan_tms(scan_tms), .scan_tdi(scan_tdi),
        .scan_test_reset_n(scan_trst_n), .scan_tdo(scan_tdo));

    rsd_host_model host_u (.hold_master(hold_master), .hold_chip(hold_chip),
        .boot_level(boot_level), .debug_level(debug_level), .tck_run(tck_run),
        .master_oe(m_oe), .chip_oe(c_oe), .strap_out(s_out), .strap_oe(s_oe),
        .master_wire(m_wire), .chip_wire(c_wire), .boot_wire(b_wire), .strap_wire(s_wire),
        .tck(tck));

    // clock, cycle ceiling and edge counters
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    // pulses counted at the falling edge, where the registered outputs are settled
    always @(negedge sys_clk) begin
        cycles++;
        n_emu    += int'(emu_rise === 1'b1);
        n_scan   += int'(scan_rise === 1'b1);
        n_emu_f  += int'(emu_fall === 1'b1);
        n_scan_f += int'(scan_fall === 1'b1);
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end
    always @(posedge tck) n_tck++;
    // returned clock only counts while the device drives the shared pin
    always @(posedge s_out) n_returned_test_clock += int'(s_oe === 1'b1);

    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // power-on pulls both reset pins, then lets go
    task automatic t_por;
        cyc(95);
        check(m_oe, 1'b1);
        check(c_oe, 1'b1);
        check(m_out, 1'b0);
        check(c_out, 1'b0);
        check(mod_rst_n, 1'b0);
        check(bb_rst_n, 1'b0);
        cyc(12);
        check(m_oe, 1'b0);
        check(c_oe, 1'b0);
        check(mod_rst_n, 1'b1);
        check(bb_rst_n, 1'b1);
        check(boot_flash, 1'b1);
        check(emu_mode, 1'b0);
        $display("test por done");
    endtask

    // straps captured at master release and held afterwards
    task automatic t_straps(input logic b, input logic d);
        hold_master = 1'b1;
        boot_level  = b;
        debug_level = d;
        cyc(6);
        check(mod_rst_n, 1'b0);
        check(s_oe, 1'b0);
        hold_master = 1'b0;
        cyc(8);
        check(boot_flash, b);
        check(emu_mode, d);
        check(s_oe, d);
        check(mod_rst_n, 1'b1);
        boot_level  = !b;
        debug_level = !d;
        cyc(15);
        check(boot_flash, b);
        check(emu_mode, d);
        $display("test straps %b%b done", b, d);
    endtask

    // test port routing, edge counts and returned clock
    task automatic t_route(input logic d);
        n_emu = 0;
        n_scan = 0;
        n_tck = 0;
        n_returned_test_clock = 0;
        n_emu_f = 0;
        n_scan_f = 0;
        tms = 1'b1;
        tdi = 1'b1;
        emu_tdo = 1'b1;
        scan_tdo = 1'b0;
        tck_run = 1'b1;
        cyc(6);
        check(emu_tms, d);
        check(scan_tdi, !d);
        check(tdo, d);
        check(emu_tdi, d);
        check(scan_tms, !d);
        check(emu_trst_n, d);
        check(scan_trst_n, !d);
        cyc(100);
        tck_run = 1'b0;
        cyc(60);
        check(n_tck > 3, 1'b1);
        check(n_emu == (d ? n_tck : 0), 1'b1);
        check(n_scan == (d ? 0 : n_tck), 1'b1);
        check(n_emu_f == (d ? n_tck : 0), 1'b1);
        check(n_scan_f == (d ? 0 : n_tck), 1'b1);
        check(n_returned_test_clock == (d ? n_tck : 0), 1'b1);
        tms = 1'b0;
        tdi = 1'b0;
        $display("test route %b done", d);
    endtask

    // outside pull on the baseband reset, and test reset apart from master
    task automatic t_side_resets;
        hold_chip = 1'b1;
        trst_n = 1'b0;
        cyc(6);
        check(bb_rst_n, 1'b0);
        check(emu_trst_n, 1'b0);
        check(mod_rst_n, 1'b1);
        hold_chip = 1'b0;
        trst_n = 1'b1;
        cyc(6);
        check(bb_rst_n, 1'b1);
        check(emu_trst_n, 1'b1);
        $display("test side resets done");
    endtask

    task automatic results;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {nrst, hold_master, hold_chip, tck_run, tms, tdi, emu_tdo, scan_tdo} = 8'h00;
        {boot_level, debug_level, trst_n} = 3'h5;
        {err_total, tests_run, cycles} = '0;
        cyc(3);
        nrst = 1'b1;
        t_por();
        for (int i = 0; i < 4; i++) begin
            t_straps(i[1], i[0]);
        end
        t_route(1'b1);
        t_side_resets();
        t_straps(1'b0, 1'b0);
        t_route(1'b0);
        results();
    end
endmodule
`default_nettype wire
